// >>> dv/card_model.sv
/*
  Card model: records the address setup, strobe and hold phases it sees.
  Assumes one access at a time from the timing block.
*/
`timescale 1ns/1ns
module card_model (
  input wire logic core_clk,
  input wire logic addr_valid,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic data_sample
);
  // ****************************************************************
  // Phase counters
  // ****************************************************************
  int setup_n;
  int strobe_n;
  int hold_n;
  int smp_n;
  logic av_q = 1'h0;
  logic seen;
  logic smp;
  // Phase lengths of the latest access
  always @(posedge core_clk) begin
    if (addr_valid && !av_q) begin
      {setup_n, strobe_n, hold_n, smp_n} = '0;
      {seen, smp} = 2'h0;
    end
    if (addr_valid) begin
      if (read_strobe || write_strobe) strobe_n++;
      else if (seen) hold_n++;
      else setup_n++;
      if (read_strobe || write_strobe) seen = 1'h1;
      if (smp) smp_n++;
      if (data_sample) smp = 1'h1;
    end
    av_q = addr_valid;
  end
endmodule // card_model

// >>> dv/card_timing_sva.sv
/*
  Port checker for the card strobe timing block.
  Assumes it is bound to every card_strobe_timing instance.
*/
`timescale 1ns/1ns
module card_timing_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire card_timing_pkg::access_req_s req,
  input wire logic busy,
  input wire logic addr_valid,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic data_sample,
  input wire logic done
);
  // ****************************************************************
  // Helper state and properties
  // ****************************************************************
  card_timing_pkg::access_req_s req_reg;
  logic [8:0] wlen_reg;
  // Request of the running access and write strobe length
  always_ff @(posedge core_clk) begin
    if (start && !busy) req_reg <= req;
    wlen_reg <= write_strobe ? wlen_reg + 9'h001 : 9'h000;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence addr_then_strobe;
    addr_valid ##1 (read_strobe || write_strobe);
  endsequence
  a_strobe_excl: assert property (!(read_strobe && write_strobe))
    else $error("both strobes high");
  a_strobe_addr: assert property ((read_strobe || write_strobe) |-> addr_valid)
    else $error("strobe without address");
  a_setup_outside: assert property (start && !busy && !req.area_5_or_6 |=> addr_then_strobe)
    else $error("setup delay outside areas");
  a_write_width: assert property ($fell(write_strobe)
    && !(req_reg.low_speed && req_reg.area_5_or_6)
    |-> wlen_reg == {1'h0, req_reg.base_waits} + 9'h001)
    else $error("write strobe width");
  a_hold_outside: assert property ($fell(write_strobe) && !req_reg.area_5_or_6
    |-> addr_valid ##1 !addr_valid)
    else $error("hold outside areas");
  a_sample_read: assert property (data_sample |-> read_strobe && !req_reg.write)
    else $error("sample outside read strobe");
  a_done_pulse: assert property (done |=> !done && !busy)
    else $error("done not a pulse");
  a_addr_cause: assert property ($rose(addr_valid) |-> $past(start) && !$past(busy))
    else $error("address without start");
  a_idle_quiet: assert property (!busy |-> !addr_valid && !read_strobe && !write_strobe)
    else $error("activity while idle");
endmodule // card_timing_sva

bind card_strobe_timing card_timing_sva card_timing_sva_i (.*);

// >>> dv/testbench.sv
/*
  Self-checking bench for the card strobe timing block.
  Assumes the card model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
module testbench;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  logic core_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic start = 1'h0, pready, pslverr, busy, addr_valid, read_strobe, write_strobe;
  logic data_sample, done, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] timing, rnd;
  card_timing_pkg::access_req_s req = '0;
  int bad_count = 0, tests_run = 0, seed = 32'hac06, cyc = 0;
  always #25 core_clk = ~core_clk;
  card_strobe_timing card_strobe_timing_i (.*);
  card_model card_model_i (.*);
  function automatic int dly(input logic [2:0] c);
    int tbl[8] = '{0, 1, 2, 3, 6, 9, 12, 15};
    return tbl[c];
  endfunction
  function automatic int xw(input logic [1:0] c);
    int tbl[4] = '{0, 15, 30, 50};
    return tbl[c];
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // APB master: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One card access, phases checked against the register value t
  task automatic access(input card_timing_pkg::access_req_s r, input logic [15:0] t);
    int s, e, h, b;
    logic [1:0] ec;
    logic [2:0] sc, hc;
    {ec, sc, hc} = r.timing_set_select ? {t[13:12], t[8:6], t[2:0]}
                                       : {t[15:14], t[11:9], t[5:3]};
    s = r.area_5_or_6 ? dly(sc) : 0;
    h = r.area_5_or_6 ? dly(hc) : 0;
    e = (r.area_5_or_6 && r.low_speed) ? xw(ec) : 0;
    b = r.base_waits;
    @(posedge core_clk);
    start <= 1'h1;
    req <= r;
    @(posedge core_clk);
    start <= 1'h0;
    do @(posedge core_clk); while (done !== 1'h1);
    #1;
    check(card_model_i.setup_n, s + 1, "setup");
    if (r.area_5_or_6 && !r.write && !r.io_card && r.timing_set_select) begin
      check(card_model_i.strobe_n, b + e + h + 2, "read strobe");
      check(card_model_i.smp_n, h + 1, "hold after sample");
    end else begin
      check(card_model_i.strobe_n, b + e + 1, "strobe");
      if (r.write || r.io_card) check(card_model_i.hold_n, h + 1, "hold");
    end
  endtask
  // Cycle ceiling against a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      end_sim;
    end
  end
  // Main sequence
  initial begin
    card_timing_pkg::access_req_s r;
    repeat (4) @(posedge core_clk);
    reset <= 1'h0;
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h0, "reset value");
    apb(1'h0, 12'h010, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    $display("Register reset test done");
    for (int i = 0; i < 16; i++) begin
      timing = 16'($random(seed));
      if (i < 8) timing = {i[1:0], i[1:0], i[2:0], i[2:0], i[2:0], i[2:0]};
      rnd = 16'($random(seed));
      apb(1'h1, 12'h000, {rnd, timing});
      apb(1'h0, 12'h000, 32'h0);
      check(rd, {16'h0, timing}, "readback");
      for (int k = 0; k < 9; k++) begin
        r = 13'($random(seed));
        r.area_5_or_6 = !k[3];
        {r.io_card, r.write, r.timing_set_select} = k[2:0] | {1'h0, k[3], 1'h0};
        r.base_waits = {5'h0, r.base_waits[2:0]};
        access(r, timing);
      end
      $display("Timing round %0d done", i);
    end
    r = '0;
    r.area_5_or_6 = 1'h1;
    r.write = 1'h1;
    r.low_speed = 1'h1;
    apb(1'h1, 12'h000, 32'h0000ffff);
    fork
      access(r, 16'hffff);
      apb(1'h1, 12'h000, 32'h0);
    join
    // Status bit read while the access runs
    fork
      access(r, 16'h0000);
      begin
        repeat (2) @(posedge core_clk);
        apb(1'h0, card_timing_pkg::status_off, 32'h0);
        check(rd, 32'h1, "busy status");
      end
    join
    $display("Write during access test done");
    apb(1'h1, 12'h000, 32'h00001234);
    reset <= 1'h1;
    repeat (2) @(posedge core_clk);
    reset <= 1'h0;
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h0, "value after reset");
    $display("Second reset test done");
    end_sim;
  end
endmodule // testbench

// >>> hw/card_strobe_timing.sv
/*
  Card strobe timing control: timing register on APB and an access
  sequencer that places the strobe between address setup and hold.
  Assumes the bus controller raises a one-cycle start with its request,
  supplies the base wait count and low-speed flag from its wait control,
  and drives the address while addr_valid is high.
*/
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module card_strobe_timing (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start,
  input wire card_timing_pkg::access_req_s req,
  output logic busy,
  output logic addr_valid,
  output logic read_strobe,
  output logic write_strobe,
  output logic data_sample,
  output logic done
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [15:0] card_access_timing_reg;
  logic [15:0] card_access_timing_next;
  logic apb_write;
  logic apb_read;
  logic hit_timing;
  logic hit_status;

  // APB decode; always ready, unmapped addresses raise an error
  always_comb begin
    hit_timing = (paddr == card_timing_pkg::card_access_timing_off);
    hit_status = (paddr == card_timing_pkg::status_off);
    apb_write = psel && penable && pwrite && hit_timing;
    apb_read = psel && !pwrite;
    pready = 1'b1;
    pslverr = psel && penable && !(hit_timing || hit_status);
    card_access_timing_next = card_access_timing_reg;
    if (apb_write) begin
      card_access_timing_next = pwdata[15:0];
    end
  end

  // Timing register, loaded with its reset value whenever reset is high
  always_ff @(posedge core_clk) begin
    if (reset) begin
      card_access_timing_reg <= card_timing_pkg::card_access_timing_rst;
    end else begin
      card_access_timing_reg <= card_access_timing_next;
    end
  end

  // ****************************************************************
  // Field set selection and decode
  // ****************************************************************
  logic [1:0] extra_code;
  logic [2:0] setup_code;
  logic [2:0] hold_code;
  card_timing_pkg::access_timing_s sel_timing;

  // Pick the field set by the select bit
  always_comb begin
    if (req.timing_set_select) begin
      extra_code = card_access_timing_reg[card_timing_pkg::set1_extra_wait_lsb +: 2];
      setup_code = card_access_timing_reg[card_timing_pkg::set1_setup_delay_lsb +: 3];
      hold_code = card_access_timing_reg[card_timing_pkg::set1_hold_delay_lsb +: 3];
    end else begin
      extra_code = card_access_timing_reg[card_timing_pkg::set0_extra_wait_lsb +: 2];
      setup_code = card_access_timing_reg[card_timing_pkg::set0_setup_delay_lsb +: 3];
      hold_code = card_access_timing_reg[card_timing_pkg::set0_hold_delay_lsb +: 3];
    end
  end

  card_wait_decode u_decode (
    .extra_code(extra_code),
    .setup_code(setup_code),
    .hold_code(hold_code),
    .timing(sel_timing)
  );

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  card_timing_pkg::access_state_e state_reg;
  card_timing_pkg::access_state_e state_next;
  logic [8:0] count_reg;
  logic [8:0] count_next;
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic write_reg;
  logic write_next;
  logic from_sample_reg;
  logic from_sample_next;
  logic [8:0] len_reg;
  logic [8:0] len_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [8:0] strobe_len;

  // Strobe length: base waits plus low-speed extra in areas 5 or 6, plus one cycle
  always_comb begin
    strobe_len = {1'b0, req.base_waits} + 9'h001;
    if (req.low_speed && req.area_5_or_6) begin
      strobe_len = strobe_len + {1'b0, sel_timing.extra_waits};
    end
  end

  // Next state and counters
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    hold_next = hold_reg;
    write_next = write_reg;
    from_sample_next = from_sample_reg;
    len_next = len_reg;
    case (state_reg)
      card_timing_pkg::st_idle: begin
        if (start) begin
          // Timing is latched here so later register writes cannot disturb it
          write_next = req.write;
          len_next = strobe_len;
          if (req.area_5_or_6) begin
            count_next = {1'b0, sel_timing.setup_waits};
            hold_next = sel_timing.hold_waits;
            from_sample_next = req.timing_set_select && !req.write && !req.io_card;
          end else begin
            count_next = 9'h000;
            hold_next = 8'h00;
            from_sample_next = 1'b0;
          end
          state_next = card_timing_pkg::st_setup;
        end
      end
      card_timing_pkg::st_setup: begin
        if (count_reg == 9'h000) begin
          count_next = len_reg;
          state_next = card_timing_pkg::st_strobe;
        end else begin
          count_next = count_reg - 9'h001;
        end
      end
      card_timing_pkg::st_strobe: begin
        if (count_reg == 9'h001) begin
          count_next = {1'b0, hold_reg};
          state_next = card_timing_pkg::st_hold;
        end else begin
          count_next = count_reg - 9'h001;
        end
      end
      card_timing_pkg::st_hold: begin
        if (count_reg == 9'h000) begin
          state_next = card_timing_pkg::st_done;
        end else begin
          count_next = count_reg - 9'h001;
        end
      end
      card_timing_pkg::st_done: begin
        state_next = card_timing_pkg::st_idle;
      end
      default: begin
        state_next = card_timing_pkg::st_idle;
      end
    endcase
  end

  // Read data: register or sequencer state
  always_comb begin
    prdata_next = prdata_reg;
    if (apb_read && !penable) begin
      if (hit_timing) begin
        prdata_next = {16'h0000, card_access_timing_reg};
      end else if (hit_status) begin
        prdata_next = {31'h00000000, busy};
      end else begin
        prdata_next = 32'h00000000;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= card_timing_pkg::st_idle;
      count_reg <= 9'h000;
      hold_reg <= 8'h00;
      write_reg <= 1'b0;
      from_sample_reg <= 1'b0;
      len_reg <= 9'h000;
      prdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      hold_reg <= hold_next;
      write_reg <= write_next;
      from_sample_reg <= from_sample_next;
      len_reg <= len_next;
      prdata_reg <= prdata_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic strobe_on;
  logic strobe_end;

  // Strobes; in sampled-hold reads the strobe stays on through the hold
  always_comb begin
    strobe_end = (state_reg == card_timing_pkg::st_strobe) && (count_reg == 9'h001);
    strobe_on = (state_reg == card_timing_pkg::st_strobe) ||
                ((state_reg == card_timing_pkg::st_hold) && from_sample_reg);
    prdata = prdata_reg;
    busy = (state_reg != card_timing_pkg::st_idle);
    addr_valid = (state_reg == card_timing_pkg::st_setup) ||
                 (state_reg == card_timing_pkg::st_strobe) ||
                 (state_reg == card_timing_pkg::st_hold);
    read_strobe = strobe_on && !write_reg;
    write_strobe = (state_reg == card_timing_pkg::st_strobe) && write_reg;
    data_sample = strobe_end && !write_reg;
    done = (state_reg == card_timing_pkg::st_done);
  end

endmodule // card_strobe_timing

// >>> hw/card_timing_pkg.sv
/*
  Package for the card strobe timing block: register offsets, field layout,
  reset value, wait encodings, state and carrier types.
  Assumes a 32-bit APB with one aligned word per register.
*/
package card_timing_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] card_access_timing_off = 12'h000;
  localparam logic [11:0] status_off = 12'h004;
  localparam logic [15:0] card_access_timing_rst = 16'h0000;

  // ****************************************************************
  // Field positions in the timing register
  // ****************************************************************
  localparam int set0_extra_wait_lsb = 14;
  localparam int set1_extra_wait_lsb = 12;
  localparam int set0_setup_delay_lsb = 9;
  localparam int set1_setup_delay_lsb = 6;
  localparam int set0_hold_delay_lsb = 3;
  localparam int set1_hold_delay_lsb = 0;

  // ****************************************************************
  // Wait encodings
  // ****************************************************************
  localparam logic [7:0] extra_wait_1 = 8'h0f;
  localparam logic [7:0] extra_wait_2 = 8'h1e;
  localparam logic [7:0] extra_wait_3 = 8'h32;
  localparam logic [7:0] delay_4 = 8'h06;
  localparam logic [7:0] delay_5 = 8'h09;
  localparam logic [7:0] delay_6 = 8'h0c;
  localparam logic [7:0] delay_7 = 8'h0f;

  // Access sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_setup,
    st_strobe,
    st_hold,
    st_done
  } access_state_e;

  // Timing chosen for one access
  typedef struct packed {
    logic [7:0] extra_waits;
    logic [7:0] setup_waits;
    logic [7:0] hold_waits;
  } access_timing_s;

  // Card access request
  typedef struct packed {
    logic area_5_or_6;
    logic timing_set_select;
    logic write;
    logic io_card;
    logic low_speed;
    logic [7:0] base_waits;
  } access_req_s;

endpackage

// >>> hw/card_wait_decode.sv
/*
  Decoder for one set of card timing fields into wait counts.
  Assumes the caller has already chosen the field set.
*/
`timescale 1ns/1ns
module card_wait_decode (
  input wire logic [1:0] extra_code,
  input wire logic [2:0] setup_code,
  input wire logic [2:0] hold_code,
  output card_timing_pkg::access_timing_s timing
);

  // ****************************************************************
  // Code to count mapping
  // ****************************************************************
  function automatic logic [7:0] delay_of(input logic [2:0] code);
    case (code)
      3'h4: delay_of = card_timing_pkg::delay_4;
      3'h5: delay_of = card_timing_pkg::delay_5;
      3'h6: delay_of = card_timing_pkg::delay_6;
      3'h7: delay_of = card_timing_pkg::delay_7;
      default: delay_of = {5'h00, code};
    endcase
  endfunction

  // Extra low-speed waits and the two delays
  always_comb begin
    case (extra_code)
      2'h1: timing.extra_waits = card_timing_pkg::extra_wait_1;
      2'h2: timing.extra_waits = card_timing_pkg::extra_wait_2;
      2'h3: timing.extra_waits = card_timing_pkg::extra_wait_3;
      default: timing.extra_waits = 8'h00;
    endcase
    timing.setup_waits = delay_of(setup_code);
    timing.hold_waits = delay_of(hold_code);
  end

endmodule // card_wait_decode
